// [design/csp_pkg.sv]
package csp_pkg;
   // ==========================================
   // output format selection
   typedef enum logic [3:0] {
      FMT_RGB32  = 4'h0,
      FMT_RED    = 4'h1,
      FMT_GREEN  = 4'h2,
      FMT_BLUE   = 4'h3,
      FMT_HSL32  = 4'h4,
      FMT_HSI32  = 4'h5,
      FMT_HUE    = 4'h6,
      FMT_SAT    = 4'h7,
      FMT_LUM    = 4'h8,
      FMT_INT    = 4'h9
   } fmt_t;

   // ==========================================
   // byte positions in a packed word
   localparam int BYTE_TOP_LSB = 24;
   localparam int BYTE_HI_LSB  = 16;
   localparam int BYTE_MID_LSB = 8;
   localparam int BYTE_LO_LSB  = 0;

   // ==========================================
   // luminance weights in 1/65536 units (0.299, 0.587, 0.114)
   localparam logic [16:0] LUM_WR = 17'h04c8b;
   localparam logic [16:0] LUM_WG = 17'h09646;
   localparam logic [16:0] LUM_WB = 17'h01d2f;
   localparam logic [24:0] LUM_HALF = 25'h0008000;

   // ==========================================
   // hue: full turn maps onto 256 codes
   localparam int HUE_CODES   = 256;
   localparam int ATAN_STEPS  = 12;
   localparam logic [7:0] SAT_FULL = 8'hff;

   // pipeline latency in clock cycles from sample to output
   localparam int PIPE_LAT = 2;

   // ==========================================
   // after reset
   localparam logic [31:0] WORD_RST  = 32'h00000000;
   localparam logic [7:0]  PLANE_RST = 8'h00;
endpackage : csp_pkg

// [design/hue_angle.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// two-argument arctangent by search over 256 sector codes,
// combinational; returns the code nearest to the angle of (x, y)
module hue_angle
   import csp_pkg::*;
(
   input  wire logic signed [10:0] x_in,
   input  wire logic signed [10:0] y_in,
   output logic         [7:0]  hue_out
);
   // angle in 1/256 turn; compare using dot products with unit vectors
   // cos/sin of code k scaled by 1024, computed by cs for each code inside the search loop
   function automatic logic signed [11:0] cs(input int k, input bit s);
      real a;
      a = 6.283185307179586 * k / HUE_CODES;
      return s ? 12'(int'($rtoi(1024.0 * $sin(a) + (($sin(a) >= 0) ? 0.5 : -0.5))))
               : 12'(int'($rtoi(1024.0 * $cos(a) + (($cos(a) >= 0) ? 0.5 : -0.5))));
   endfunction : cs

   always_comb begin
      logic signed [23:0] best;
      logic signed [23:0] dot;
      logic signed [23:0] xs;
      logic signed [23:0] ys;
      best    = -24'sd8388607;
      dot     = '0;
      xs      = 24'(x_in);
      ys      = 24'(y_in);
      hue_out = 8'h00;
      // pick the direction with the largest projection: nearest angle code
      for (int k = 0; k < HUE_CODES; k++) begin
         dot = 24'(xs * 24'(cs(k, 1'b0)) + ys * 24'(cs(k, 1'b1)));
         if (dot > best) begin
            best    = dot;
            hue_out = 8'(k);
         end
      end
   end
endmodule : hue_angle
`default_nettype wire

// [design/color_space_pixel_formatter.sv]
`timescale 1ns/1ps
`default_nettype none
module color_space_pixel_formatter
   import csp_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        in_valid,
   input  wire logic [7:0]  in_red,
   input  wire logic [7:0]  in_green,
   input  wire logic [7:0]  in_blue,
   input  wire logic [3:0]  fmt_sel,
   input  wire logic        core_en,
   input  wire logic [7:0]  core_thresh,
   output logic             out_valid,
   output logic             out_wide,
   output logic [31:0]      out_word,
   output logic [7:0]       out_plane
);
   // ==========================================
   // stage 1: arithmetic on the input sample
   logic [9:0]         sum_c;
   logic [7:0]         min_c;
   logic [24:0]        lum_acc;
   logic signed [10:0] hx_c;
   logic signed [10:0] hy_c;
   logic [7:0]         hue_c;
   logic [7:0]         lum_c;
   logic [7:0]         int_c;
   logic [7:0]         sat_c;
   logic [17:0]        sat_num;
   logic [17:0]        sat_q;

   always_comb begin
      sum_c   = 10'(in_red) + 10'(in_green) + 10'(in_blue);
      min_c   = (in_red < in_green) ? in_red : in_green;
      min_c   = (in_blue < min_c) ? in_blue : min_c;
      lum_acc = 25'(in_red) * 25'(LUM_WR) + 25'(in_green) * 25'(LUM_WG)
              + 25'(in_blue) * 25'(LUM_WB) + LUM_HALF;
      lum_c   = (lum_acc[24:16] > 9'h0ff) ? 8'hff : lum_acc[23:16];
      int_c   = 8'((sum_c + 10'h001) / 10'h003);
      // same angle after multiplying both axes by sqrt6: y*sqrt3, x
      hx_c    = 11'(2 * $signed({3'h0, in_red})) - $signed({3'h0, in_green})
              - $signed({3'h0, in_blue});
      hy_c    = $signed({3'h0, in_green}) - $signed({3'h0, in_blue});
      // 255*(sum-3min)/sum, rounded to nearest
      sat_num = 18'(SAT_FULL) * 18'(sum_c - 10'(3 * min_c));
      if (sum_c == 10'h000) begin
         sat_q = '0;
      end else begin
         sat_q = (sat_num + 18'(sum_c >> 1)) / 18'(sum_c);
      end
      sat_c = sat_q[7:0];
   end

   // y scaled by sqrt3 (~ 1774/1024) so the angle matches the formula
   logic signed [21:0] hy_mul;
   logic signed [10:0] hy_s;
   always_comb begin
      hy_mul = 22'(hy_c) * 22'sd1774;
      hy_s   = 11'(hy_mul >>> 10);
   end

   hue_angle u_hue (
      .x_in    (hx_c),
      .y_in    (hy_s),
      .hue_out (hue_c)
   );

   // ==========================================
   // stage 1 registers
   logic       v1_reg,   v1_next;
   logic [7:0] r1_reg,   r1_next;
   logic [7:0] g1_reg,   g1_next;
   logic [7:0] b1_reg,   b1_next;
   logic [7:0] h1_reg,   h1_next;
   logic [7:0] s1_reg,   s1_next;
   logic [7:0] l1_reg,   l1_next;
   logic [7:0] i1_reg,   i1_next;
   logic [3:0] f1_reg,   f1_next;

   always_comb begin
      v1_next = in_valid;
      r1_next = in_red;
      g1_next = in_green;
      b1_next = in_blue;
      s1_next = sat_c;
      l1_next = lum_c;
      i1_next = int_c;
      f1_next = fmt_sel;
      if ((sum_c == 10'h000) || (hx_c == 11'sd0 && hy_c == 11'sd0)) begin
         h1_next = 8'h00;
      end else if (core_en && (sat_c < core_thresh)) begin
         h1_next = 8'h00;
      end else begin
         h1_next = hue_c;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         v1_reg <= 1'b0;
         r1_reg <= PLANE_RST;
         g1_reg <= PLANE_RST;
         b1_reg <= PLANE_RST;
         h1_reg <= PLANE_RST;
         s1_reg <= PLANE_RST;
         l1_reg <= PLANE_RST;
         i1_reg <= PLANE_RST;
         f1_reg <= 4'h0;
      end else begin
         v1_reg <= v1_next;
         r1_reg <= r1_next;
         g1_reg <= g1_next;
         b1_reg <= b1_next;
         h1_reg <= h1_next;
         s1_reg <= s1_next;
         l1_reg <= l1_next;
         i1_reg <= i1_next;
         f1_reg <= f1_next;
      end
   end

   // ==========================================
   // stage 2: output formatting
   logic        ov_reg,    ov_next;
   logic        ow_reg,    ow_next;
   logic [31:0] word_reg,  word_next;
   logic [7:0]  plane_reg, plane_next;

   always_comb begin
      ov_next    = v1_reg;
      ow_next    = 1'b0;
      word_next  = WORD_RST;
      plane_next = PLANE_RST;
      unique case (f1_reg)
         FMT_RGB32: begin
            ow_next   = 1'b1;
            word_next = {8'h00, r1_reg, g1_reg, b1_reg};
         end
         FMT_HSL32: begin
            ow_next   = 1'b1;
            word_next = {8'h00, h1_reg, s1_reg, l1_reg};
         end
         FMT_HSI32: begin
            ow_next   = 1'b1;
            word_next = {8'h00, h1_reg, s1_reg, i1_reg};
         end
         FMT_RED:   plane_next = r1_reg;
         FMT_GREEN: plane_next = g1_reg;
         FMT_BLUE:  plane_next = b1_reg;
         FMT_HUE:   plane_next = h1_reg;
         FMT_SAT:   plane_next = s1_reg;
         FMT_LUM:   plane_next = l1_reg;
         FMT_INT:   plane_next = i1_reg;
         default: begin
            ov_next = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         ov_reg    <= 1'b0;
         ow_reg    <= 1'b0;
         word_reg  <= WORD_RST;
         plane_reg <= PLANE_RST;
      end else begin
         ov_reg    <= ov_next;
         ow_reg    <= ow_next;
         word_reg  <= word_next;
         plane_reg <= plane_next;
      end
   end

   assign out_valid = ov_reg;
   assign out_wide  = ow_reg;
   assign out_word  = word_reg;
   assign out_plane = plane_reg;

   // ==========================================
   // assertions
   a_rgb_pack_order: assert property (@(posedge clk) disable iff (rst)
      (in_valid && fmt_sel == FMT_RGB32) |-> ##2
      (out_valid && out_word == {8'h00, $past(in_red, 2), $past(in_green, 2), $past(in_blue, 2)}))
      else $error("packed colour word wrong");
   a_rgb_top_zero: assert property (@(posedge clk) disable iff (rst)
      (out_valid && out_wide) |-> out_word[31:24] == 8'h00)
      else $error("top byte not zero");
   a_red_plane: assert property (@(posedge clk) disable iff (rst)
      (in_valid && fmt_sel == FMT_RED) |-> ##2 (out_plane == $past(in_red, 2) && !out_wide))
      else $error("red plane wrong");
   a_intensity_val: assert property (@(posedge clk) disable iff (rst)
      (in_valid && fmt_sel == FMT_INT) |-> ##2
      (out_plane == 8'((10'($past(in_red, 2)) + 10'($past(in_green, 2)) + 10'($past(in_blue, 2)) + 10'h001) / 10'h003)))
      else $error("intensity wrong");
   a_gray_lum_same: assert property (@(posedge clk) disable iff (rst)
      (in_valid && fmt_sel == FMT_LUM && in_red == in_green && in_green == in_blue) |-> ##2
      (out_plane == $past(in_red, 2)))
      else $error("grey luminance wrong");
   a_zero_pixel_hs: assert property (@(posedge clk) disable iff (rst)
      (in_valid && fmt_sel == FMT_HSL32 && {in_red, in_green, in_blue} == 24'h000000) |-> ##2
      (out_word[23:8] == 16'h0000))
      else $error("black pixel hue or saturation not zero");
   a_grey_sat_zero: assert property (@(posedge clk) disable iff (rst)
      (in_valid && fmt_sel == FMT_SAT && in_red == in_green && in_green == in_blue) |-> ##2
      (out_plane == 8'h00))
      else $error("grey saturation not zero");
   a_pure_sat_full: assert property (@(posedge clk) disable iff (rst)
      (in_valid && fmt_sel == FMT_SAT && in_red != 8'h00 && in_green == 8'h00 && in_blue == 8'h00) |-> ##2
      (out_plane == 8'hff))
      else $error("pure colour saturation not full");
   a_hue_coring: assert property (@(posedge clk) disable iff (rst)
      (in_valid && fmt_sel == FMT_HUE && core_en && sat_c < core_thresh) |-> ##2 (out_plane == 8'h00))
      else $error("cored hue not cleared");
   a_red_hue_zero: assert property (@(posedge clk) disable iff (rst)
      (in_valid && fmt_sel == FMT_HUE && !core_en && in_red == 8'hff && in_green == 8'h00 && in_blue == 8'h00)
      |-> ##2 (out_plane == 8'h00))
      else $error("red hue not zero");
   a_hsi_layout: assert property (@(posedge clk) disable iff (rst)
      (in_valid && fmt_sel == FMT_HSI32) |-> ##2 (out_wide && out_word[31:24] == 8'h00))
      else $error("hsi packing wrong");
   a_plane_narrow: assert property (@(posedge clk) disable iff (rst)
      (in_valid && fmt_sel >= FMT_HUE && fmt_sel <= FMT_INT) |-> ##2 (out_valid && !out_wide))
      else $error("plane mode flagged wide");
   a_valid_latency: assert property (@(posedge clk) disable iff (rst)
      (in_valid && fmt_sel <= FMT_INT) |-> ##2 out_valid)
      else $error("output valid missing");

   c_rgb_mode: cover property (@(posedge clk) disable iff (rst) out_valid && f1_reg == 4'h0 && out_wide);
   c_hsl_mode: cover property (@(posedge clk) disable iff (rst) ##1 out_valid && out_wide && $past(f1_reg) == FMT_HSL32);
   c_cored:    cover property (@(posedge clk) disable iff (rst) in_valid && core_en && sat_c < core_thresh);
   c_plane:    cover property (@(posedge clk) disable iff (rst) out_valid && !out_wide);
endmodule : color_space_pixel_formatter
`default_nettype wire

// [verif/px_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// upstream pixel source and downstream word sink
module px_model (
   input  wire logic        clk,
   output logic             v,
   output logic [7:0]       r,
   output logic [7:0]       g,
   output logic [7:0]       b,
   input  wire logic        o_v,
   input  wire logic        o_wide,
   input  wire logic [31:0] o_word,
   input  wire logic [7:0]  o_plane
);
   logic [40:0] got[$];

   initial begin
      v = 1'b0;
      r = 8'h00;
      g = 8'h00;
      b = 8'h00;
   end

   // one pixel, taken at the next rising edge
   task send(input logic [7:0] rr, input logic [7:0] gg, input logic [7:0] bb);
      v = 1'b1;
      r = rr;
      g = gg;
      b = bb;
      @(posedge clk);
      #1;
   endtask : send

   // between pixels the lines carry no stale sample
   task idle;
      v = 1'b0;
      r = ~r;
      g = ~g;
      b = ~b;
   endtask : idle

   // collect at the falling edge, once the outputs launched by the rising edge have settled
   always @(negedge clk) begin
      if (o_v === 1'b1) begin
         got.push_back({o_wide, o_word, o_plane});
      end
   end
endmodule : px_model
`default_nettype wire

// [verif/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import csp_pkg::*;
   logic        clk;
   logic        rst;
   logic        in_valid;
   logic [7:0]  in_red;
   logic [7:0]  in_green;
   logic [7:0]  in_blue;
   logic [3:0]  fmt_sel;
   logic        core_en;
   logic [7:0]  core_thresh;
   logic        out_valid;
   logic        out_wide;
   logic [31:0] out_word;
   logic [7:0]  out_plane;
   logic [40:0] w;
   int          n_mismatch = 0;
   int          checked = 0;

   color_space_pixel_formatter uut (.clk(clk), .rst(rst), .in_valid(in_valid), .in_red(in_red),
      .in_green(in_green), .in_blue(in_blue), .fmt_sel(fmt_sel), .core_en(core_en),
      .core_thresh(core_thresh), .out_valid(out_valid), .out_wide(out_wide), .out_word(out_word),
      .out_plane(out_plane));
   px_model m (.clk(clk), .v(in_valid), .r(in_red), .g(in_green), .b(in_blue), .o_v(out_valid),
      .o_wide(out_wide), .o_word(out_word), .o_plane(out_plane));

   // ==========================================
   // helpers
   task check(input logic [40:0] seen, input logic [40:0] exp);
      checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   function logic near(input logic [7:0] a, input logic [7:0] e);
      return (8'(a - e + 8'h01) <= 8'h02);
   endfunction : near

   function logic [7:0] lum(input int rr, input int gg, input int bb);
      return 8'((19595 * rr + 38470 * gg + 7471 * bb + 32768) >> 16);
   endfunction : lum

   function logic [7:0] sat(input int rr, input int gg, input int bb);
      int s;
      int mn;
      s = rr + gg + bb;
      mn = (rr < gg) ? rr : gg;
      mn = (mn < bb) ? mn : bb;
      if (s == 0) return 8'h00;
      return 8'((510 * (s - 3 * mn) + s) / (2 * s));
   endfunction : sat

   task px(input logic [3:0] f, input logic [7:0] rr, input logic [7:0] gg, input logic [7:0] bb);
      fmt_sel = f;
      m.send(rr, gg, bb);
   endtask : px

   task flush;
      m.idle();
      repeat (5) @(posedge clk);
      #1;
   endtask : flush

   task take(output logic [40:0] x);
      if (m.got.size() == 0) x = 'x;
      else x = m.got.pop_front();
   endtask : take

   task hue_is(input logic [7:0] e);
      take(w);
      check({40'h0, near(w[7:0], e)}, 41'h1);
   endtask : hue_is

   task chk3(input logic [7:0] rr, input logic [7:0] gg, input logic [7:0] bb);
      px(FMT_LUM, rr, gg, bb);
      px(FMT_INT, rr, gg, bb);
      px(FMT_SAT, rr, gg, bb);
      flush();
      take(w);
      check(w, {33'h0, lum(rr, gg, bb)});
      take(w);
      check(w, {33'h0, 8'((rr + gg + bb + 1) / 3)});
      take(w);
      check(w, {33'h0, sat(rr, gg, bb)});
   endtask : chk3

   // ==========================================
   // scenarios
   task t_packs;
      px(FMT_RGB32, 8'h12, 8'h34, 8'h56);
      px(FMT_RED, 8'ha1, 8'hb2, 8'hc3);
      px(FMT_GREEN, 8'ha1, 8'hb2, 8'hc3);
      px(FMT_BLUE, 8'ha1, 8'hb2, 8'hc3);
      px(FMT_RGB32, 8'hff, 8'h80, 8'h01);
      flush();
      take(w);
      check(w, 41'h10012345600);
      take(w);
      check(w, 41'h000000000a1);
      take(w);
      check(w, 41'h000000000b2);
      take(w);
      check(w, 41'h000000000c3);
      take(w);
      check(w, 41'h100ff800100);
      $display("test packs done");
   endtask : t_packs

   task t_quant;
      chk3(8'hff, 8'hff, 8'hff);
      chk3(8'h10, 8'h80, 8'hf0);
      chk3(8'h00, 8'h00, 8'h00);
      chk3(8'hc0, 8'h00, 8'h00);
      $display("test quantities done");
   endtask : t_quant

   task t_hue;
      px(FMT_HUE, 8'hff, 8'h00, 8'h00);
      px(FMT_HUE, 8'h00, 8'hff, 8'h00);
      px(FMT_HUE, 8'h00, 8'h00, 8'hff);
      px(FMT_HUE, 8'h00, 8'h00, 8'h00);
      px(FMT_HUE, 8'h80, 8'h80, 8'h80);
      flush();
      hue_is(8'h00);
      hue_is(8'h55);
      hue_is(8'hab);
      hue_is(8'h00);
      hue_is(8'h00);
      $display("test hue done");
   endtask : t_hue

   task t_hsx;
      px(FMT_HSL32, 8'h64, 8'hc8, 8'h64);
      px(FMT_HSI32, 8'h64, 8'hc8, 8'h64);
      px(FMT_HSL32, 8'h00, 8'h00, 8'h00);
      flush();
      take(w);
      check(41'({w[40:32], w[23:0]}), 41'({9'h100, 8'h40, lum(100, 200, 100), 8'h00}));
      check({40'h0, near(w[31:24], 8'h55)}, 41'h1);
      take(w);
      check(41'({w[40:32], w[23:0]}), 41'({9'h100, 8'h40, 8'h85, 8'h00}));
      check({40'h0, near(w[31:24], 8'h55)}, 41'h1);
      take(w);
      check(w, 41'h10000000000);
      $display("test packed hsl hsi done");
   endtask : t_hsx

   task t_core;
      core_en = 1'b1;
      core_thresh = 8'h41;
      px(FMT_HUE, 8'h64, 8'hc8, 8'h64);
      core_thresh = 8'h40;
      px(FMT_HUE, 8'h64, 8'hc8, 8'h64);
      core_en = 1'b0;
      core_thresh = 8'hff;
      px(FMT_HUE, 8'h64, 8'hc8, 8'h64);
      flush();
      take(w);
      check(w, 41'h0);
      hue_is(8'h55);
      hue_is(8'h55);
      $display("test coring done");
   endtask : t_core

   task t_bad;
      px(4'ha, 8'h11, 8'h22, 8'h33);
      px(4'hf, 8'h11, 8'h22, 8'h33);
      flush();
      check(41'(m.got.size()), 41'h0);
      $display("test illegal format done");
   endtask : t_bad

   task stop_test;
      $display("comparisons %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : stop_test

   // ==========================================
   // clock, reset, sequence
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   initial begin
      #200000;
      n_mismatch++;
      stop_test();
   end

   initial begin
      rst = 1'b1;
      fmt_sel = 4'h0;
      core_en = 1'b0;
      core_thresh = 8'h00;
      repeat (2) @(posedge clk);
      #1;
      rst = 1'b0;
      check({out_valid, out_word, out_plane}, 41'h0);
      // first pixel only after the edge that sees reset low
      @(posedge clk);
      #1;
      t_packs();
      t_quant();
      t_hue();
      t_hsx();
      t_core();
      t_bad();
      stop_test();
   end
endmodule : tb_top
`default_nettype wire
